// >>> core/clock_sync_serial_pkg.sv
// constants shared by the clock-synchronous serial port
package clock_sync_serial_pkg;

	// =====================================================================
	// register byte addresses
	localparam logic [7:0] MODE_ADDR = 8'h00;
	localparam logic [7:0] CTRL0_ADDR = 8'h04;
	localparam logic [7:0] CTRL1_ADDR = 8'h08;
	localparam logic [7:0] PINCTRL_ADDR = 8'h0c;
	localparam logic [7:0] BITRATE_ADDR = 8'h10;
	localparam logic [7:0] TXBUF_ADDR = 8'h14;
	localparam logic [7:0] RXBUF_ADDR = 8'h18;
	localparam logic [7:0] TXIRQ_ADDR = 8'h1c;

	// =====================================================================
	// field positions
	localparam int MODE_EXT_CLK = 3;
	localparam int MODE_SLEEP = 7;
	localparam int C0_FLOW_RTS = 2;
	localparam int C0_TXE = 3;
	localparam int C0_FLOW_OFF = 4;
	localparam int C0_POL = 6;
	localparam int C0_MSB = 7;
	localparam int C1_TE = 0;
	localparam int C1_TBE = 1;
	localparam int C1_RE = 2;
	localparam int C1_FULL = 3;
	localparam int C1_OVR = 4;
	localparam int PIN_TX0 = 2;
	localparam int PIN_TX1 = 3;
	localparam int PIN_TX2 = 5;

	// =====================================================================
	// reset values and fixed figures
	localparam logic [2:0] SYNC_MODE_CODE = 3'h1;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CTRL0_RST = 8'h08;
	localparam logic [7:0] PINCTRL_RST = 8'h00;
	localparam logic [7:0] BITRATE_RST = 8'h00;
	localparam logic [3:0] FRAME_BITS = 4'h8;
	localparam logic [4:0] FRAME_EDGES = 5'h10;

	// source clock prescale terminal counts, selected by clock_source_sel bits
	localparam logic [5:0] PRE_DIV1 = 6'h00;
	localparam logic [5:0] PRE_DIV8 = 6'h07;
	localparam logic [5:0] PRE_DIV32 = 6'h1f;
	localparam logic [5:0] PRE_DIV64 = 6'h3f;

	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage : clock_sync_serial_pkg

// >>> core/clock_sync_serial_port.sv
// clock-synchronous serial port with apb register access
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module clock_sync_serial_port #(
	parameter int PRESCALE_W = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic rxd,
	output logic txd,
	output logic [2:0] txd_pin_en,
	input wire logic flow_in,
	output logic flow_out,
	output logic flow_oe
);

	// elaboration check: the prescaler must reach the largest terminal count
	if (PRESCALE_W < 6)
	begin : g_bad_prescale
		$error("PRESCALE_W must hold the largest prescale count");
	end

	// =====================================================================
	// helpers
	function automatic logic [7:0] reverse8(input logic [7:0] v, input logic en);
		logic [7:0] r;
		r = v;
		for (int i = 0; i < 8; i++)
			r[i] = en ? v[7 - i] : v[i];
		return r;
	endfunction : reverse8

	// =====================================================================
	// register state
	logic [7:0] mode_reg;
	logic [7:0] ctrl0;
	logic [7:0] pin_ctrl;
	logic [7:0] bit_rate;
	logic [7:0] tx_buffer;
	logic [7:0] rx_buffer;
	logic clock_source_sel_lo;
	logic clock_source_sel_hi;
	logic transmit_enable_flag;
	logic tx_buffer_empty_flag;
	logic tx_register_empty_flag;
	logic receive_enable_flag;
	logic rx_buffer_full_flag;
	logic overrun_error_flag;
	logic tx_irq_req;
	logic [31:0] next_prdata;

	// apb decode: no wait states, data latched in the setup cycle
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	wire wr_mode = wr_en && paddr == clock_sync_serial_pkg::MODE_ADDR;
	wire wr_c0 = wr_en && paddr == clock_sync_serial_pkg::CTRL0_ADDR;
	wire wr_c1 = wr_en && paddr == clock_sync_serial_pkg::CTRL1_ADDR;
	wire wr_pin = wr_en && paddr == clock_sync_serial_pkg::PINCTRL_ADDR;
	wire wr_rate = wr_en && paddr == clock_sync_serial_pkg::BITRATE_ADDR;
	wire wr_txbuf = wr_en && paddr == clock_sync_serial_pkg::TXBUF_ADDR;
	wire wr_irq = wr_en && paddr == clock_sync_serial_pkg::TXIRQ_ADDR;
	wire rd_rxbuf = rd_en && paddr == clock_sync_serial_pkg::RXBUF_ADDR;
	wire mapped = paddr <= clock_sync_serial_pkg::TXIRQ_ADDR && paddr[1:0] == 2'h0;
	assign pready = penable;
	assign pslverr = psel & penable & ~mapped;

	// =====================================================================
	// mode decode
	wire sync_mode = mode_reg[2:0] == clock_sync_serial_pkg::SYNC_MODE_CODE;
	wire ext_clk = mode_reg[clock_sync_serial_pkg::MODE_EXT_CLK];
	wire pol = ctrl0[clock_sync_serial_pkg::C0_POL];
	wire msb_first = ctrl0[clock_sync_serial_pkg::C0_MSB];
	wire flow_used = ~ctrl0[clock_sync_serial_pkg::C0_FLOW_OFF];
	wire flow_is_rts = ctrl0[clock_sync_serial_pkg::C0_FLOW_RTS];
	wire cts_ok = ~flow_used | flow_is_rts | ~flow_in;

	// read mux, error bits of control1 other than overrun read zero
	wire [7:0] ctrl1_rd = {3'h0, overrun_error_flag, rx_buffer_full_flag, receive_enable_flag,
		tx_buffer_empty_flag, transmit_enable_flag};
	wire [7:0] ctrl0_rd = {ctrl0[7:4], tx_register_empty_flag, ctrl0[2],
		clock_source_sel_hi, clock_source_sel_lo};
	always_comb
	begin
		next_prdata = 32'h0;
		if (paddr == clock_sync_serial_pkg::MODE_ADDR)
			next_prdata[7:0] = mode_reg;
		else if (paddr == clock_sync_serial_pkg::CTRL0_ADDR)
			next_prdata[7:0] = ctrl0_rd;
		else if (paddr == clock_sync_serial_pkg::CTRL1_ADDR)
			next_prdata[7:0] = ctrl1_rd;
		else if (paddr == clock_sync_serial_pkg::PINCTRL_ADDR)
			next_prdata[7:0] = pin_ctrl;
		else if (paddr == clock_sync_serial_pkg::BITRATE_ADDR)
			next_prdata[7:0] = bit_rate;
		else if (paddr == clock_sync_serial_pkg::TXBUF_ADDR)
			next_prdata[7:0] = tx_buffer;
		else if (paddr == clock_sync_serial_pkg::RXBUF_ADDR)
			next_prdata[7:0] = reverse8(rx_buffer, msb_first);
		else if (paddr == clock_sync_serial_pkg::TXIRQ_ADDR)
			next_prdata[0] = tx_irq_req;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup)
			prdata <= next_prdata;
	end

	// =====================================================================
	// plain configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg <= clock_sync_serial_pkg::MODE_RST;
			ctrl0 <= clock_sync_serial_pkg::CTRL0_RST;
			pin_ctrl <= clock_sync_serial_pkg::PINCTRL_RST;
			bit_rate <= clock_sync_serial_pkg::BITRATE_RST;
			clock_source_sel_lo <= 1'b0;
			clock_source_sel_hi <= 1'b0;
			transmit_enable_flag <= 1'b0;
			receive_enable_flag <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= {1'b0, pwdata[6:0]}; // bit 7 kept at zero
			if (wr_c0)
			begin
				ctrl0 <= pwdata[7:0];
				clock_source_sel_lo <= pwdata[0];
				clock_source_sel_hi <= pwdata[1];
			end
			if (wr_pin)
				pin_ctrl <= pwdata[7:0];
			if (wr_rate)
				bit_rate <= pwdata[7:0];
			if (wr_c1)
			begin
				transmit_enable_flag <= pwdata[clock_sync_serial_pkg::C1_TE];
				receive_enable_flag <= pwdata[clock_sync_serial_pkg::C1_RE];
			end
		end
	end

	// =====================================================================
	// internal shift clock: prescale, then n+1 divider, then toggle
	logic [PRESCALE_W-1:0] pre_cnt;
	logic [7:0] rate_cnt;
	logic sclk;
	clock_sync_serial_pkg::tx_state_t tx_state;
	wire tx_busy = tx_state == clock_sync_serial_pkg::TX_SHIFT;
	wire [PRESCALE_W-1:0] pre_top = PRESCALE_W'(
		{clock_source_sel_hi, clock_source_sel_lo} == 2'h0 ? clock_sync_serial_pkg::PRE_DIV1 :
		{clock_source_sel_hi, clock_source_sel_lo} == 2'h1 ? clock_sync_serial_pkg::PRE_DIV8 :
		{clock_source_sel_hi, clock_source_sel_lo} == 2'h2 ? clock_sync_serial_pkg::PRE_DIV32 :
		clock_sync_serial_pkg::PRE_DIV64);
	wire src_tick = pre_cnt == pre_top;
	wire half_tick = src_tick && rate_cnt == bit_rate && tx_busy && !ext_clk;

	// dividers run only during a byte so each byte starts on a full half period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_cnt <= '0;
			rate_cnt <= 8'h0;
		end
		else if (!tx_busy)
		begin
			pre_cnt <= '0;
			rate_cnt <= 8'h0;
		end
		else
		begin
			pre_cnt <= src_tick ? '0 : pre_cnt + 1'b1;
			if (src_tick)
				rate_cnt <= rate_cnt == bit_rate ? 8'h0 : rate_cnt + 8'h1;
		end
	end

	// shift clock level, idles at the polarity's rest level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sclk <= 1'b1;
		else if (!tx_busy)
			sclk <= ~pol;
		else if (half_tick)
			sclk <= ~sclk;
	end

	// edge detection on whichever clock is active
	logic clk_prev;
	wire clk_now = ext_clk ? sclk_in : sclk;
	wire clk_rise = clk_now & ~clk_prev;
	wire clk_fall = ~clk_now & clk_prev;
	wire out_edge = pol ? clk_rise : clk_fall;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_prev <= 1'b1;
		else
			clk_prev <= clk_now;
	end

	// =====================================================================
	// transmitter
	logic [7:0] tx_shift;
	logic [4:0] tx_edges;
	logic tend_prev;
	wire transmit_end_signal = ~tx_busy;
	wire tx_load = transmit_end_signal && sync_mode && transmit_enable_flag
		&& !tx_buffer_empty_flag && cts_ok;
	wire tx_done = tx_busy && tx_edges == clock_sync_serial_pkg::FRAME_EDGES;

	// only the edge count ends a byte, never enable or clear-to-send
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= clock_sync_serial_pkg::TX_IDLE;
			tx_shift <= 8'h0;
			tx_edges <= 5'h0;
			txd <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_state <= clock_sync_serial_pkg::TX_SHIFT;
			tx_shift <= tx_buffer;
			tx_edges <= 5'h0;
		end
		else if (tx_done)
			tx_state <= clock_sync_serial_pkg::TX_IDLE;
		else if (tx_busy && (clk_rise || clk_fall))
		begin
			tx_edges <= tx_edges + 5'h1;
			if (out_edge)
			begin
				txd <= tx_shift[0];
				tx_shift <= {1'b0, tx_shift[7:1]};
			end
		end
	end

	// buffer-empty: a write always wins, since it brings a new byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_buffer <= 8'h0;
			tx_buffer_empty_flag <= 1'b1;
		end
		else if (wr_txbuf)
		begin
			tx_buffer <= reverse8(pwdata[7:0], msb_first);
			tx_buffer_empty_flag <= 1'b0;
		end
		else if (tx_load)
			tx_buffer_empty_flag <= 1'b1;
	end

	// register-empty one cycle after the end signal rises; a start clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tend_prev <= 1'b1;
			tx_register_empty_flag <= 1'b1;
		end
		else
		begin
			tend_prev <= transmit_end_signal;
			if (tx_load)
				tx_register_empty_flag <= 1'b0;
			else if (transmit_end_signal && !tend_prev)
				tx_register_empty_flag <= 1'b1;
		end
	end

	// transmit interrupt request: set wins over a software clear
	wire tbe_rise = wr_txbuf ? 1'b0 : tx_load;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_irq_req <= 1'b0;
		else if (tbe_rise)
			tx_irq_req <= 1'b1;
		else if (wr_irq)
			tx_irq_req <= pwdata[0];
	end

	// =====================================================================
	// receiver
	logic [7:0] rx_shift;
	logic [3:0] rx_bits;
	logic rts_hold;
	wire rx_on = receive_enable_flag && sync_mode;
	wire rx_sample = rx_on && clk_rise;
	wire rx_xfer = rx_sample && rx_bits == clock_sync_serial_pkg::FRAME_BITS - 4'h1;

	// shift in lsb first; the byte lands in the buffer on the eighth rising edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_shift <= 8'h0;
			rx_bits <= 4'h0;
			rx_buffer <= 8'h0;
		end
		else if (!rx_on)
			rx_bits <= 4'h0;
		else if (rx_sample)
		begin
			rx_shift <= {rxd, rx_shift[7:1]};
			rx_bits <= rx_xfer ? 4'h0 : rx_bits + 4'h1;
			if (rx_xfer)
				rx_buffer <= {rxd, rx_shift[7:1]};
		end
	end

	// status flags: a new byte wins over a same-cycle buffer read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_buffer_full_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			rts_hold <= 1'b0;
		end
		else if (!receive_enable_flag)
		begin
			rx_buffer_full_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
			rts_hold <= 1'b0;
		end
		else
		begin
			if (rx_xfer)
				rx_buffer_full_flag <= 1'b1;
			else if (rd_rxbuf)
				rx_buffer_full_flag <= 1'b0;
			if (rx_xfer && rx_buffer_full_flag)
				overrun_error_flag <= 1'b1;
			if (rx_sample && rx_bits == 4'h0)
				rts_hold <= 1'b1;
			else if (rd_rxbuf)
				rts_hold <= 1'b0;
		end
	end

	// =====================================================================
	// pins; the receive clock always comes from the peer when external
	assign sclk_out = sclk;
	assign sclk_oe = sync_mode & ~ext_clk;
	assign flow_out = ~receive_enable_flag | rts_hold;
	assign flow_oe = sync_mode & flow_used & flow_is_rts;
	assign txd_pin_en[0] = sync_mode & ~pin_ctrl[clock_sync_serial_pkg::PIN_TX0];
	assign txd_pin_en[1] = sync_mode & ~pin_ctrl[clock_sync_serial_pkg::PIN_TX1];
	assign txd_pin_en[2] = sync_mode & ~pin_ctrl[clock_sync_serial_pkg::PIN_TX2];

	// =====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence byte_running;
		tx_busy [*2];
	endsequence

	tbe_on_write_a: assert property (wr_txbuf |=> !tx_buffer_empty_flag)
		else $error("buffer-empty still set after buffer write");
	tbe_on_load_a: assert property (tx_load && !wr_txbuf |=> tx_buffer_empty_flag)
		else $error("buffer-empty not set after load");
	start_gate_a: assert property (tx_load |-> transmit_enable_flag && cts_ok
		&& !tx_buffer_empty_flag && !tx_busy)
		else $error("transmission started without its conditions");
	no_abort_a: assert property (tx_load |=> byte_running)
		else $error("byte aborted right after start");
	txe_timing_a: assert property ($rose(transmit_end_signal) && !tx_load
		|=> tx_register_empty_flag)
		else $error("register-empty flag late");
	irq_set_a: assert property ($rose(tx_buffer_empty_flag) |-> tx_irq_req)
		else $error("buffer-empty rise without interrupt request");
	overrun_set_a: assert property (rx_xfer && rx_buffer_full_flag && receive_enable_flag
		|=> overrun_error_flag)
		else $error("overrun not flagged");
	full_set_a: assert property (rx_xfer |=> rx_buffer_full_flag
		&& rx_buffer == {$past(rxd), $past(rx_shift[7:1])})
		else $error("receive buffer not filled");
	rts_idle_a: assert property (!receive_enable_flag |-> flow_out)
		else $error("request-to-send low while receive disabled");
	// a polarity write moves the rest level one cycle later
	clk_idle_a: assert property (!tx_busy ##1 (!tx_busy && $stable(pol)) |-> sclk == ~pol)
		else $error("shift clock not at rest level");
	err_bits_a: assert property (setup && paddr == clock_sync_serial_pkg::CTRL1_ADDR
		|=> prdata[7:5] == 3'h0)
		else $error("error bits set in sync mode");

endmodule : clock_sync_serial_port

// >>> verif/peer_serial_model.sv
// far-side clock-synchronous serial port model
`timescale 1ns/1ps

// =====================================================================
// peer port: shifts in on rising clock, shifts out on falling clock
module peer_serial_model #(
	parameter int HALF_PERIOD = 5
) (
	input wire logic pclk,
	input wire logic sclk_line,
	input wire logic txd,
	input wire logic ext_go,
	input wire logic [7:0] send_byte,
	output logic peer_sclk,
	output logic rxd_line,
	output logic [15:0] got_word
);
	logic [2:0] tx_idx;

	// idle levels before any frame
	initial
	begin
		peer_sclk = 1'b1;
		rxd_line = 1'b1;
		got_word = 16'h0000;
		tx_idx = 3'h0;
	end

	// clock-sending role: 16 edges a byte, clock stands still between frames
	always @(posedge ext_go)
	begin
		repeat (16)
		begin
			repeat (HALF_PERIOD) @(posedge pclk);
			peer_sclk <= ~peer_sclk;
		end
	end

	// own data goes out lsb first on the falling edge
	always @(negedge sclk_line)
	begin
		rxd_line <= send_byte[tx_idx];
		tx_idx <= tx_idx + 3'h1;
	end

	// sample on rising edge; three pclk cycles after the eighth bit the line is inverted
	always @(posedge sclk_line)
	begin
		got_word <= {txd, got_word[15:1]};
		if (tx_idx == 3'h0)
		begin
			repeat (3) @(posedge pclk);
			rxd_line <= ~rxd_line;
		end
	end
endmodule : peer_serial_model

// >>> verif/testbench.sv
// self-checking testbench for the clock-synchronous serial port
`timescale 1ns/1ps

// =====================================================================
// bench top
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclk_out;
	logic sclk_oe;
	logic txd;
	logic [2:0] txd_pin_en;
	logic flow_in = 1'b1;
	logic flow_out;
	logic flow_oe;
	logic peer_sclk;
	logic rxd_line;
	logic [15:0] peer_word;
	logic ext_go = 1'b0;
	logic [7:0] send_byte = 8'h00;
	logic sclk_line;
	logic [31:0] rdata;
	logic [31:0] err;
	logic prev_sclk = 1'b1;
	logic [31:0] hp_cnt = 32'h0;
	logic [31:0] hp_seen = 32'h0;
	int mismatches = 0;
	int check_count = 0;

	// the shift clock line is driven by whichever side has it enabled
	assign sclk_line = sclk_oe ? sclk_out : peer_sclk;

	always #5 pclk = ~pclk;

	clock_sync_serial_port u_clock_sync_serial_port (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(peer_sclk),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .rxd(rxd_line), .txd(txd),
		.txd_pin_en(txd_pin_en), .flow_in(flow_in), .flow_out(flow_out), .flow_oe(flow_oe));

	peer_serial_model u_peer_serial_model (.pclk(pclk), .sclk_line(sclk_line), .txd(txd),
		.ext_go(ext_go), .send_byte(send_byte), .peer_sclk(peer_sclk),
		.rxd_line(rxd_line), .got_word(peer_word));

	// half period of the internal shift clock, in pclk cycles
	always @(posedge pclk)
	begin
		if (sclk_out !== prev_sclk)
		begin
			hp_seen <= hp_cnt;
			hp_cnt <= 32'h1;
		end
		else
			hp_cnt <= hp_cnt + 32'h1;
		prev_sclk <= sclk_out;
	end

	// =====================================================================
	// checking and closing
	task automatic tally_and_finish;
		$display("mismatches=%0d checks=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// =====================================================================
	// apb master: hold the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 16)
			begin
				mismatches++;
				tally_and_finish();
			end
			@(posedge pclk);
		end
		rdata = prdata;
		err = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdata, {24'h000000, exp});
	endtask : rd

	// poll one register bit, bounded
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		apb(1'b0, a, 8'h00);
		while (rdata[b] !== v)
		begin
			n++;
			if (n > 300)
			begin
				mismatches++;
				tally_and_finish();
			end
			apb(1'b0, a, 8'h00);
		end
	endtask : wait_bit

	// =====================================================================
	// scenarios
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(clock_sync_serial_pkg::MODE_ADDR, 8'h00);
		rd(clock_sync_serial_pkg::CTRL0_ADDR, 8'h08);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h02);
		chk(flow_out, 32'h1);
		rd(8'h20, 8'h00);
		chk(err, 32'h1);
		// polarity change while the clock pin is not driven, so the peer sees no edge
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h40);
		@(posedge pclk);
		chk(sclk_out, 32'h0);
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h00);
		apb(1'b1, clock_sync_serial_pkg::MODE_ADDR, 8'h81);
		rd(clock_sync_serial_pkg::MODE_ADDR, 8'h01);
		apb(1'b1, clock_sync_serial_pkg::PINCTRL_ADDR, 8'h2c);
		chk(txd_pin_en, 32'h0);
		apb(1'b1, clock_sync_serial_pkg::PINCTRL_ADDR, 8'h08);
		chk(txd_pin_en, 32'h5);
		// clear-to-send gating, then a byte that cannot be stopped
		apb(1'b1, clock_sync_serial_pkg::BITRATE_ADDR, 8'h04);
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h00);
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h01);
		apb(1'b1, clock_sync_serial_pkg::TXBUF_ADDR, 8'ha5);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h01);
		rd(clock_sync_serial_pkg::CTRL0_ADDR, 8'h08);
		flow_in <= 1'b0;
		wait_bit(clock_sync_serial_pkg::CTRL0_ADDR, clock_sync_serial_pkg::C0_TXE, 1'b0);
		flow_in <= 1'b1;
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h00);
		rd(clock_sync_serial_pkg::TXIRQ_ADDR, 8'h01);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h02);
		wait_bit(clock_sync_serial_pkg::CTRL0_ADDR, clock_sync_serial_pkg::C0_TXE, 1'b1);
		chk(peer_word[15:8], 32'ha5);
		chk(hp_seen, 32'h5);
		// back-to-back bytes while receiving, overrun on the second
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h10);
		send_byte <= 8'h3c;
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h05);
		apb(1'b1, clock_sync_serial_pkg::TXBUF_ADDR, 8'h11);
		wait_bit(clock_sync_serial_pkg::CTRL1_ADDR, clock_sync_serial_pkg::C1_TBE, 1'b1);
		apb(1'b1, clock_sync_serial_pkg::TXBUF_ADDR, 8'h22);
		wait_bit(clock_sync_serial_pkg::CTRL1_ADDR, clock_sync_serial_pkg::C1_OVR, 1'b1);
		wait_bit(clock_sync_serial_pkg::CTRL0_ADDR, clock_sync_serial_pkg::C0_TXE, 1'b1);
		chk(peer_word, 32'h2211);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h1f);
		rd(clock_sync_serial_pkg::RXBUF_ADDR, 8'h3c);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h17);
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h01);
		rd(clock_sync_serial_pkg::CTRL1_ADDR, 8'h03);
		// msb first reverses at the buffers only
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h91);
		send_byte <= 8'h01;
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h05);
		apb(1'b1, clock_sync_serial_pkg::TXBUF_ADDR, 8'h01);
		wait_bit(clock_sync_serial_pkg::CTRL0_ADDR, clock_sync_serial_pkg::C0_TXE, 1'b0);
		wait_bit(clock_sync_serial_pkg::CTRL0_ADDR, clock_sync_serial_pkg::C0_TXE, 1'b1);
		chk(peer_word[15:8], 32'h80);
		chk(hp_seen, 32'h28);
		wait_bit(clock_sync_serial_pkg::CTRL1_ADDR, clock_sync_serial_pkg::C1_FULL, 1'b1);
		rd(clock_sync_serial_pkg::RXBUF_ADDR, 8'h80);
		// external clock reception with request-to-send
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h00);
		apb(1'b1, clock_sync_serial_pkg::MODE_ADDR, 8'h09);
		apb(1'b1, clock_sync_serial_pkg::CTRL0_ADDR, 8'h04);
		chk(sclk_oe, 32'h0);
		chk(flow_oe, 32'h1);
		chk(flow_out, 32'h1);
		apb(1'b1, clock_sync_serial_pkg::CTRL1_ADDR, 8'h04);
		chk(flow_out, 32'h0);
		send_byte <= 8'hc3;
		ext_go <= 1'b1;
		wait_bit(clock_sync_serial_pkg::CTRL1_ADDR, clock_sync_serial_pkg::C1_FULL, 1'b1);
		chk(flow_out, 32'h1);
		rd(clock_sync_serial_pkg::RXBUF_ADDR, 8'hc3);
		chk(flow_out, 32'h0);
		ext_go <= 1'b0;
		tally_and_finish();
	end

	// hang guard
	initial
	begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		tally_and_finish();
	end
endmodule : testbench
